// ==== logic/pewl_top.sv ====
`timescale 1ns/1ns
module pewl_top
   import pewl_pkg::*;
#(
   parameter int PULSE_CYC = PEWL_PULSE_CYC
) (
   input  wire logic                      sys_clk,
   input  wire logic                      srst,
   input  wire logic                      clk_en,
   input  wire logic                      pm_event_in_1,
   input  wire logic                      pm_event_in_2,
   input  wire logic                      modem_call_indicator_1,
   input  wire logic                      modem_call_indicator_2,
   input  wire logic                      ring_pin_a,
   input  wire logic                      ring_pin_b,
   input  wire logic                      switch_off_event,
   input  wire logic                      supply_off_event,
   input  wire logic [1:0]                pm_event_in_1_det_mode,
   input  wire logic [1:0]                pm_event_in_2_det_mode,
   input  wire logic [PEWL_ROUTE_W-1:0]   pm_event_in_1_route,
   input  wire logic [PEWL_ROUTE_W-1:0]   pm_event_in_2_route,
   input  wire logic                      modem_wake_en,
   input  wire logic                      ring_wake_en,
   input  wire logic                      power_ctl_cfg_1_por_level,
   input  wire logic                      power_ctl_cfg_2_ring_sel,
   input  wire logic                      por_out_type,
   input  wire logic                      por_pullup_en,
   input  wire logic                      sci_clear,
   output logic                           power_off_request_o,
   output logic                           power_off_request_oe_n,
   output logic                           power_off_request_pullup,
   output logic                           sci_event,
   output logic                           supply_on_control,
   output logic [PEWL_NUM_PME-1:0]        pme_status
);
   localparam int NSYNC = 6;
   localparam int CW    = $clog2(PULSE_CYC + 1);

   initial begin
      if (PULSE_CYC < 1) $error("pewl_top: PULSE_CYC must be at least 1");
   end

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   pewl_sync_if #(.N(NSYNC)) sif ();
   assign sif.raw = {ring_pin_b, ring_pin_a, modem_call_indicator_2, modem_call_indicator_1,
                     pm_event_in_2, pm_event_in_1};

   pewl_sync #(.N(NSYNC)) u_sync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .sif     (sif)
   );

   logic [PEWL_NUM_PME-1:0] pme_s;
   logic [1:0]              mci_s;
   logic                    ring_s;
   assign pme_s  = sif.synced[1:0];
   assign mci_s  = sif.synced[3:2];
   // pin mux after sync: both candidates are synced, so switching is glitch free
   assign ring_s = power_ctl_cfg_2_ring_sel ? sif.synced[5] : sif.synced[4];

   // ------------------------------------------------------------
   // detection
   // ------------------------------------------------------------
   function automatic logic pewl_detect(input logic [1:0] mode, input logic cur, input logic prev);
      case (mode)
         PEWL_DET_LOW:  pewl_detect = ~cur;
         PEWL_DET_HIGH: pewl_detect = cur;
         PEWL_DET_RISE: pewl_detect = cur & ~prev;
         PEWL_DET_FALL: pewl_detect = ~cur & prev;
         default:       pewl_detect = 1'b0;
      endcase
   endfunction

   logic [PEWL_NUM_PME-1:0] pme_prev_r;
   logic [PEWL_NUM_PME-1:0] pme_prev_nxt;
   logic [1:0]              mci_prev_r;
   logic [1:0]              mci_prev_nxt;
   logic                    ring_prev_r;
   logic                    ring_prev_nxt;
   logic [PEWL_NUM_PME-1:0] pme_hit;
   logic [1:0]              pme_mode [PEWL_NUM_PME];
   logic [PEWL_ROUTE_W-1:0] pme_rt   [PEWL_NUM_PME];

   assign pme_mode[0] = pm_event_in_1_det_mode;
   assign pme_mode[1] = pm_event_in_2_det_mode;
   assign pme_rt[0]   = pm_event_in_1_route;
   assign pme_rt[1]   = pm_event_in_2_route;

   genvar gi;
   generate
      for (gi = 0; gi < PEWL_NUM_PME; gi++) begin : g_pme
         assign pme_hit[gi] = pewl_detect(pme_mode[gi], pme_s[gi], pme_prev_r[gi]);
      end
   endgenerate

   logic to_por;
   logic to_sci;
   logic to_on;
   logic mci_fall;
   logic ring_low;

   always_comb begin
      to_por = 1'b0;
      to_sci = 1'b0;
      to_on  = 1'b0;
      for (int i = 0; i < PEWL_NUM_PME; i++) begin
         to_por = to_por | (pme_hit[i] & pme_rt[i][PEWL_ROUTE_POR]);
         to_sci = to_sci | (pme_hit[i] & pme_rt[i][PEWL_ROUTE_SCI]);
         to_on  = to_on  | (pme_hit[i] & pme_rt[i][PEWL_ROUTE_ON]);
      end
   end

   assign mci_fall = modem_wake_en & |(mci_prev_r & ~mci_s);
   // a high-to-low transition of the selected ring pin counts, so a single pulse or a train both wake
   assign ring_low = ring_wake_en & ring_prev_r & ~ring_s;

   // ------------------------------------------------------------
   // output state
   // ------------------------------------------------------------
   logic          por_r;
   logic          por_nxt;
   logic [CW-1:0] por_cnt_r;
   logic [CW-1:0] por_cnt_nxt;
   logic          on_r;
   logic          on_nxt;
   logic          sci_r;
   logic          sci_nxt;
   logic [PEWL_NUM_PME-1:0] st_r;
   logic [PEWL_NUM_PME-1:0] st_nxt;
   logic          por_trig;

   // switch off bypasses any fail-safe wait
   assign por_trig = switch_off_event | to_por;

   always_comb begin
      pme_prev_nxt = pme_prev_r;
      mci_prev_nxt = mci_prev_r;
      ring_prev_nxt = ring_prev_r;
      por_nxt      = por_r;
      por_cnt_nxt  = por_cnt_r;
      on_nxt       = on_r;
      sci_nxt      = sci_r;
      st_nxt       = st_r;
      if (srst) begin
         pme_prev_nxt  = {PEWL_NUM_PME{PEWL_SYNC_RST}};
         mci_prev_nxt  = {2{PEWL_SYNC_RST}};
         ring_prev_nxt = PEWL_SYNC_RST;
         por_nxt       = 1'b0;
         por_cnt_nxt   = '0;
         on_nxt        = 1'b0;
         sci_nxt       = 1'b0;
         st_nxt        = '0;
      end else if (clk_en) begin
         pme_prev_nxt  = pme_s;
         mci_prev_nxt  = mci_s;
         ring_prev_nxt = ring_s;
         if (por_trig) begin
            por_nxt     = 1'b1;
            por_cnt_nxt = CW'(PULSE_CYC);
         end else if (!power_ctl_cfg_1_por_level) begin
            // edge mode: fixed-width pulse
            if (por_cnt_r > CW'(1)) begin
               por_cnt_nxt = por_cnt_r - CW'(1);
            end else begin
               por_cnt_nxt = '0;
               por_nxt     = 1'b0;
            end
         end else if (on_r) begin
            // level mode holds until the supply is commanded back on
            por_nxt = 1'b0;
         end
         // set wins over the off event in the same cycle
         if (to_on | mci_fall | ring_low) begin
            on_nxt = 1'b1;
         end else if (por_trig | supply_off_event) begin
            on_nxt = 1'b0;
         end
         st_nxt  = (st_r & {PEWL_NUM_PME{~sci_clear}}) | pme_hit;
         sci_nxt = to_sci | (sci_r & ~sci_clear);
      end
   end

   always_ff @(posedge sys_clk) begin
      pme_prev_r  <= pme_prev_nxt;
      mci_prev_r  <= mci_prev_nxt;
      ring_prev_r <= ring_prev_nxt;
      por_r       <= por_nxt;
      por_cnt_r   <= por_cnt_nxt;
      on_r        <= on_nxt;
      sci_r       <= sci_nxt;
      st_r        <= st_nxt;
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   // open drain only drives while the request is high; push-pull drives both levels
   assign power_off_request_o      = por_r;
   assign power_off_request_oe_n   = (por_out_type == PEWL_OTYPE_PP) ? 1'b0 : ~por_r;
   assign power_off_request_pullup = por_pullup_en;
   assign supply_on_control        = on_r;
   assign sci_event                = sci_r;
   assign pme_status               = st_r;
endmodule

// ==== logic/pewl_pkg.sv ====
package pewl_pkg;

   // ------------------------------------------------------------
   // event detection modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PEWL_DET_LOW  = 2'h0,
      PEWL_DET_HIGH = 2'h1,
      PEWL_DET_RISE = 2'h2,
      PEWL_DET_FALL = 2'h3
   } pewl_det_type;

   // ------------------------------------------------------------
   // event routing targets, one enable bit each
   // ------------------------------------------------------------
   localparam int PEWL_ROUTE_W   = 3;
   localparam int PEWL_ROUTE_POR = 0;
   localparam int PEWL_ROUTE_SCI = 1;
   localparam int PEWL_ROUTE_ON  = 2;

   // ------------------------------------------------------------
   // power off request pin buffer types
   // ------------------------------------------------------------
   localparam logic PEWL_OTYPE_OD = 1'h0;
   localparam logic PEWL_OTYPE_PP = 1'h1;

   localparam int  PEWL_NUM_PME  = 2;
   localparam int  PEWL_SYNC_W   = 2;
   localparam int  PEWL_PULSE_NS = 16;
   localparam int  PEWL_CLK_MHZ  = 250;
   localparam int  PEWL_PULSE_CYC_I = (PEWL_PULSE_NS * PEWL_CLK_MHZ) / 1000;
   localparam int  PEWL_PULSE_CYC = (PEWL_PULSE_CYC_I < 1) ? 1 : PEWL_PULSE_CYC_I;

   localparam logic PEWL_SYNC_RST = 1'h1;

endpackage

// ==== logic/pewl_sync_if.sv ====
`timescale 1ns/1ns
interface pewl_sync_if #(parameter int N = 5);
   logic [N-1:0] raw;
   logic [N-1:0] synced;
   modport src (output raw,    input  synced);
   modport snk (input  raw,    output synced);
endinterface

// ==== logic/pewl_sync.sv ====
`timescale 1ns/1ns
module pewl_sync
   import pewl_pkg::*;
#(
   parameter int N = 5
) (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic clk_en,
   pewl_sync_if.snk  sif
);
   logic [N-1:0] meta_r;
   logic [N-1:0] meta_nxt;
   logic [N-1:0] sync_r;
   logic [N-1:0] sync_nxt;

   initial begin
      if (N < 1) $error("pewl_sync: N must be at least 1");
   end

   always_comb begin
      meta_nxt = meta_r;
      sync_nxt = sync_r;
      if (srst) begin
         meta_nxt = {N{PEWL_SYNC_RST}};
         sync_nxt = {N{PEWL_SYNC_RST}};
      end else if (clk_en) begin
         meta_nxt = sif.raw;
         sync_nxt = meta_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
   end

   assign sif.synced = sync_r;
endmodule

// ==== testbench/pewl_chk_props.sv ====
`timescale 1ns/1ns
module pewl_chk
   import pewl_pkg::*;
#(
   parameter int PULSE_CYC = 2
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic modem_call_indicator_1,
   input wire logic modem_wake_en,
   input wire logic ring_pin_b,
   input wire logic ring_wake_en,
   input wire logic power_ctl_cfg_2_ring_sel,
   input wire logic switch_off_event,
   input wire logic supply_off_event,
   input wire logic power_ctl_cfg_1_por_level,
   input wire logic por_out_type,
   input wire logic sci_clear,
   input wire logic power_off_request_o,
   input wire logic power_off_request_oe_n,
   input wire logic sci_event,
   input wire logic supply_on_control
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // pulse length count is fixed at 2, the bench builds with that value
   sequence off_trig;
      clk_en && switch_off_event;
   endsequence
   sequence quiet;
      clk_en && !switch_off_event && !power_ctl_cfg_1_por_level;
   endsequence
   sequence on_late;
      ##1 !supply_on_control[*2] ##[1:2] supply_on_control;
   endsequence
   off_at_once_a: assert property (off_trig |=> power_off_request_o)
      else $error("off request not raised at once");
   pulse_end_a: assert property (off_trig ##1 quiet[*2] |=> !power_off_request_o)
      else $error("off request pulse too long");
   level_hold_a: assert property (power_off_request_o && power_ctl_cfg_1_por_level && clk_en
      && !supply_on_control |=> power_off_request_o || supply_on_control) else $error("off level dropped");
   pin_buffer_a: assert property (power_off_request_oe_n
      == (por_out_type == PEWL_OTYPE_OD && !power_off_request_o)) else $error("off pin buffer wrong");
   modem_wake_a: assert property (clk_en && modem_wake_en && $fell(modem_call_indicator_1)
      && !supply_on_control && !supply_off_event |-> on_late) else $error("modem wake timing");
   ring_wake_a: assert property (clk_en && ring_wake_en && power_ctl_cfg_2_ring_sel
      && $fell(ring_pin_b) && !supply_on_control |-> on_late) else $error("ring wake timing");
   sci_sticky_a: assert property (sci_event && !sci_clear |=> sci_event)
      else $error("sci event lost");
   supply_off_a: assert property (clk_en && supply_off_event |=> !supply_on_control)
      else $error("supply not switched off");
endmodule

// ==== testbench/pewl_supply_model.sv ====
`timescale 1ns/1ns
module pewl_supply_model (
   input  wire logic sys_clk,
   input  wire logic por_o,
   input  wire logic por_oe_n,
   input  wire logic por_pullup,
   output logic      por_wire
);
   // released pin shows no stale value unless pulled up
   assign por_wire = !por_oe_n ? por_o : (por_pullup ? 1'h1 : !por_o);
endmodule

// ==== testbench/test_power_event_wake_logic.sv ====
`timescale 1ns/1ns
module test_power_event_wake_logic
   import pewl_pkg::*;
   ;
   logic sys_clk, srst, clk_en, pm_event_in_1, pm_event_in_2, switch_off_event, supply_off_event;
   logic modem_call_indicator_1, modem_call_indicator_2, ring_pin_a, ring_pin_b, sci_clear;
   logic modem_wake_en, ring_wake_en, power_ctl_cfg_1_por_level, power_ctl_cfg_2_ring_sel;
   logic por_out_type, por_pullup_en, power_off_request_o, power_off_request_oe_n;
   logic power_off_request_pullup, sci_event, supply_on_control, por_wire, idle;
   logic [1:0] pm_event_in_1_det_mode, pm_event_in_2_det_mode;
   logic [PEWL_NUM_PME-1:0] pme_status;
   logic [PEWL_ROUTE_W-1:0] pm_event_in_1_route, pm_event_in_2_route;
   int num_errors = 0, num_checks = 0, cyc = 0;
   pewl_top #(.PULSE_CYC(2)) dut_u (.*);
   pewl_supply_model sup_u (.sys_clk(sys_clk), .por_o(power_off_request_o),
      .por_oe_n(power_off_request_oe_n), .por_pullup(power_off_request_pullup), .por_wire(por_wire));
   initial begin
      sys_clk = 1'h0;
      forever #2 sys_clk = ~sys_clk;
   end
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task chk(input logic [7:0] e, input logic [7:0] a);
      num_checks++;
      if (a !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask
   task off_pulse;
      supply_off_event = 1'h1;
      tick(1);
      supply_off_event = 1'h0;
   endtask
   task set_pin(input int k, input logic v);
      case (k)
         0: modem_call_indicator_1 = v;
         1: modem_call_indicator_2 = v;
         2: ring_pin_a = v;
         default: ring_pin_b = v;
      endcase
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         tally_and_finish;
      end
   end
   // ----
   // main sequence
   // ----
   initial begin
      {srst, clk_en, pm_event_in_1, modem_call_indicator_1, modem_call_indicator_2} = 5'h1f;
      {ring_pin_a, ring_pin_b, pm_event_in_2, switch_off_event, supply_off_event, sci_clear} = 6'h30;
      {modem_wake_en, ring_wake_en, power_ctl_cfg_1_por_level, power_ctl_cfg_2_ring_sel} = 4'h0;
      {por_out_type, por_pullup_en, pm_event_in_1_det_mode, pm_event_in_2_det_mode, pm_event_in_1_route, pm_event_in_2_route} = 12'h0;
      tick(8);
      srst = 1'h0;
      chk(0, {power_off_request_o, sci_event, supply_on_control, pme_status});
      switch_off_event = 1'h1;
      tick(1);
      switch_off_event = 1'h0;
      chk(1, power_off_request_o);
      tick(1);
      chk(1, power_off_request_o);
      tick(1);
      chk(0, power_off_request_o);
      set_pin(0, 1'h0);
      tick(4);
      chk(0, supply_on_control);
      set_pin(0, 1'h1);
      {modem_wake_en, ring_wake_en} = 2'h3;
      for (int k = 0; k < 4; k++) begin
         power_ctl_cfg_2_ring_sel = (k == 3);
         tick(4);
         off_pulse;
         chk(0, supply_on_control);
         set_pin(k, 1'h0);
         tick(2);
         chk(0, supply_on_control);
         tick(1);
         chk(1, supply_on_control);
         set_pin(k, 1'h1);
      end
      power_ctl_cfg_1_por_level = 1'h1;
      switch_off_event = 1'h1;
      tick(1);
      switch_off_event = 1'h0;
      tick(6);
      chk(2, {power_off_request_o, supply_on_control});
      set_pin(3, 1'h0);
      tick(4);
      chk(1, {power_off_request_o, supply_on_control});
      {ring_pin_b, power_ctl_cfg_1_por_level, por_pullup_en} = 3'h5;
      tick(1);
      chk(7, {power_off_request_oe_n, power_off_request_pullup, por_wire});
      {por_out_type, por_pullup_en} = {PEWL_OTYPE_PP, 1'h0};
      tick(1);
      chk(0, {power_off_request_oe_n, power_off_request_pullup, por_wire});
      for (int m = 0; m < 4; m++) begin
         idle = (m == PEWL_DET_LOW || m == PEWL_DET_FALL);
         {pm_event_in_1, pm_event_in_1_det_mode, pm_event_in_1_route} = {idle, m[1:0], 3'h0};
         tick(4);
         off_pulse;
         pm_event_in_1_route = 3'h1 << PEWL_ROUTE_ON;
         tick(1);
         chk(0, supply_on_control);
         pm_event_in_1 = !idle;
         tick(3);
         chk(1, supply_on_control);
         {pm_event_in_1, pm_event_in_1_route} = {idle, 3'h0};
      end
      {pm_event_in_2_det_mode, pm_event_in_2_route, sci_clear} = {PEWL_DET_RISE, 3'h3, 1'h1};
      tick(1);
      sci_clear = 1'h0;
      pm_event_in_2 = 1'h1;
      tick(3);
      chk(8'he, {power_off_request_o, sci_event, pme_status});
      tick(3);
      chk(1, sci_event);
      sci_clear = 1'h1;
      tick(1);
      sci_clear = 1'h0;
      chk(0, {sci_event, pme_status});
      tally_and_finish;
   end
endmodule
bind pewl_top pewl_chk #(.PULSE_CYC(PULSE_CYC)) chk_u (.*);
